/* cmpc_pkg.sv */
// cmpc_pkg: register map, field positions and reset values of the comparator control block.
// assumes a classic wishbone slave with 32-bit data, one control register per comparator instance.
`default_nettype none
package cmpc_pkg;
	// instance count and address layout
	localparam int          CMPC_MAX_INST    = 8;
	localparam logic [7:0]  CMPC_CTRL_BASE   = 8'h00;   // control register of instance n at base + 4*n
	localparam logic [7:0]  CMPC_STATUS_OFF  = 8'h20;   // status output of every instance in one word
	// control register field positions
	localparam int          CMPC_ON_BIT      = 7;
	localparam int          CMPC_OUT_BIT     = 6;
	localparam int          CMPC_RSV_HI_BIT  = 5;
	localparam int          CMPC_INVERT_BIT  = 4;
	localparam int          CMPC_FILTER_BIT  = 3;
	localparam int          CMPC_RSV_LO_BIT  = 2;
	localparam int          CMPC_HYST_BIT    = 1;
	localparam int          CMPC_SYNC_BIT    = 0;
	// reset value of the control register, reserved bits read one
	localparam logic [7:0]  CMPC_CTRL_RESET  = 8'h24;
	// filter length in system clocks
	localparam int          CMPC_FILTER_LEN  = 2;

	// configuration held per instance
	typedef struct packed {
		logic comparatorEnable;
		logic outputInvertSelect;
		logic zeroLatencyFilterEnable;
		logic hysteresisEnable;
		logic timerAlignedOutput;
	} cmpc_cfg_type;

	// outputs of one instance
	typedef struct packed {
		logic statusOut;
		logic pinOut;
	} cmpc_out_type;
endpackage
`default_nettype wire

/* cmpc_channel.sv */
// cmpc_channel: output conditioning for one comparator: gate, polarity, filter, timer re-timing.
// assumes the analog result and the timer clock arrive asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module cmpc_channel
	import cmpc_pkg::*;
(
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	// configuration
	input  wire cmpc_pkg::cmpc_cfg_type cfg,
	// analog side
	input  wire logic                 analogResult,
	input  wire logic                 timerClk,
	// outputs
	output var  cmpc_pkg::cmpc_out_type chOut
);
	logic [2:0] resSync_ff;
	logic [2:0] tmrSync_ff;
	logic       resStable_ff;
	logic       tmrStable_ff;
	logic       tmrPrev_ff;
	logic       filtered_ff;
	logic [1:0] agree_ff;
	logic       aligned_ff;
	logic       polarized;
	logic       conditioned;

	// three-stage synchronisers; only stages two and three are compared
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			resSync_ff <= 3'h0;
			tmrSync_ff <= 3'h0;
		end
		else
		begin
			resSync_ff <= {resSync_ff[1:0], analogResult};
			tmrSync_ff <= {tmrSync_ff[1:0], timerClk};
		end
	end

	// a change counts once the last two stages agree
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			resStable_ff <= 1'b0;
			tmrStable_ff <= 1'b0;
		end
		else
		begin
			if (resSync_ff[1] == resSync_ff[2])
				resStable_ff <= resSync_ff[2];
			if (tmrSync_ff[1] == tmrSync_ff[2])
				tmrStable_ff <= tmrSync_ff[2];
		end
	end

	// disabled comparator gives low before any conditioning
	assign polarized = (resStable_ff & cfg.comparatorEnable) ^ cfg.outputInvertSelect;

	// filter: a new level is passed once it has stood for the filter length
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			agree_ff    <= 2'h0;
			filtered_ff <= 1'b0;
		end
		else if (polarized == filtered_ff)
			agree_ff <= 2'h0;
		else if (agree_ff == 2'(CMPC_FILTER_LEN - 1))
		begin
			filtered_ff <= polarized;
			agree_ff    <= 2'h0;
		end
		else
			agree_ff <= agree_ff + 2'h1;
	end

	assign conditioned = cfg.zeroLatencyFilterEnable ? filtered_ff : polarized;

	// re-time on the falling edge of the timer clock
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			tmrPrev_ff <= 1'b0;
			aligned_ff <= 1'b0;
		end
		else
		begin
			tmrPrev_ff <= tmrStable_ff;
			if (tmrPrev_ff && !tmrStable_ff)
				aligned_ff <= conditioned;
		end
	end

	// status always follows the live result; only the pin path is re-timed
	always_comb
	begin
		chOut.statusOut = conditioned;
		chOut.pinOut    = cfg.timerAlignedOutput ? aligned_ff : conditioned;
	end
endmodule
`default_nettype wire

/* cmpc_top.sv */
// cmpc_top: wishbone register file and per-instance conditioning for up to eight comparators.
// assumes a classic wishbone master; analog results and timer clocks are asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module cmpc_top
	import cmpc_pkg::*;
#(
	parameter int NUM_INST = CMPC_MAX_INST
)
(
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	// wishbone slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	// analog core
	input  wire logic [NUM_INST-1:0]  analogResult,
	output logic      [NUM_INST-1:0]  comparatorEnable,
	output logic      [NUM_INST-1:0]  hysteresisEnable,
	// timer clock sources
	input  wire logic [NUM_INST-1:0]  timerClk,
	// outputs to timer and pin
	output logic      [NUM_INST-1:0]  comparatorPinOut
);
	import cmpc_pkg::*;

	logic [7:0]          ctrl_ff [NUM_INST];
	logic                ack_ff;
	logic [31:0]         rdData_ff;
	logic [NUM_INST-1:0] statusBits;
	logic                busReq;

	// decode of a control register address; -1 when none
	function automatic int ctrlIndex(input logic [7:0] adr);
		int idx;
		idx = -1;
		for (int k = 0; k < NUM_INST; k++)
			if (adr == CMPC_CTRL_BASE + 8'(4 * k))
				idx = k;
		return idx;
	endfunction

	assign busReq = wb_cyc_i && wb_stb_i && !ack_ff;

	// one ack per request, dropped in the cycle after it is given
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			ack_ff <= 1'b0;
		else
			ack_ff <= busReq;
	end

	// per-instance control register and conditioning channel
	for (genvar i = 0; i < NUM_INST; i++)
	begin : g_inst
		cmpc_cfg_type cfg;
		cmpc_out_type chOut;

		// reserved bits are forced to one regardless of the written value
		always_ff @(posedge sys_clk)
		begin
			if (rst)
				ctrl_ff[i] <= CMPC_CTRL_RESET;
			else if (busReq && wb_we_i && wb_sel_i[0] && ctrlIndex(wb_adr_i) == i)
			begin
				ctrl_ff[i]                  <= wb_dat_i[7:0];
				ctrl_ff[i][CMPC_OUT_BIT]    <= 1'b0;
				ctrl_ff[i][CMPC_RSV_HI_BIT] <= 1'b1;
				ctrl_ff[i][CMPC_RSV_LO_BIT] <= 1'b1;
			end
		end

		always_comb
		begin
			cfg.comparatorEnable        = ctrl_ff[i][CMPC_ON_BIT];
			cfg.outputInvertSelect      = ctrl_ff[i][CMPC_INVERT_BIT];
			cfg.zeroLatencyFilterEnable = ctrl_ff[i][CMPC_FILTER_BIT];
			cfg.hysteresisEnable        = ctrl_ff[i][CMPC_HYST_BIT];
			cfg.timerAlignedOutput      = ctrl_ff[i][CMPC_SYNC_BIT];
		end

		cmpc_channel u_channel (
			.sys_clk      (sys_clk),
			.rst          (rst),
			.cfg          (cfg),
			.analogResult (analogResult[i]),
			.timerClk     (timerClk[i]),
			.chOut        (chOut)
		);

		assign comparatorEnable[i] = cfg.comparatorEnable;
		assign hysteresisEnable[i] = cfg.comparatorEnable & cfg.hysteresisEnable;
		assign statusBits[i]       = chOut.statusOut;
		assign comparatorPinOut[i] = chOut.pinOut;
	end

	// read mux; the output bit is live status, not stored
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			rdData_ff <= 32'h0;
		else if (busReq && !wb_we_i)
		begin
			rdData_ff <= 32'h0;
			if (wb_adr_i == CMPC_STATUS_OFF)
				rdData_ff <= 32'(statusBits);
			for (int k = 0; k < NUM_INST; k++)
				if (ctrlIndex(wb_adr_i) == k)
				begin
					rdData_ff[7:0]          <= ctrl_ff[k];
					rdData_ff[CMPC_OUT_BIT] <= statusBits[k];
				end
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdData_ff;
endmodule
`default_nettype wire

/* cmpc_assertions.sv */
// cmpc_assertions: port-level checks of the comparator control block.
// assumes a bind onto cmpc_top and a classic wishbone master that holds until ack.
`timescale 1ns/1ps
`default_nettype none
module cmpc_assertions #(parameter int NUM_INST = 8)
(
	// clock, reset and bus
	input wire logic                sys_clk,
	input wire logic                rst,
	input wire logic                wb_cyc_i,
	input wire logic                wb_stb_i,
	input wire logic                wb_we_i,
	input wire logic [7:0]          wb_adr_i,
	input wire logic [3:0]          wb_sel_i,
	input wire logic [31:0]         wb_dat_i,
	input wire logic [31:0]         wb_dat_o,
	input wire logic                wb_ack_o,
	// analog core controls
	input wire logic [NUM_INST-1:0] comparatorEnable,
	input wire logic [NUM_INST-1:0] hysteresisEnable
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// read and write answers; request is still held in the ack cycle
	wire logic rdAck = wb_ack_o && !wb_we_i;
	wire logic wrAck = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00;
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	chk_rsv_ones: assert property (rdAck && wb_adr_i < 8'(4 * NUM_INST) && wb_adr_i[1:0] == 2'h0 |-> wb_dat_o[5] && wb_dat_o[2])
		else $error("reserved bit low");
	chk_upper_zero: assert property (rdAck && wb_adr_i < 8'h20 |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_unmapped_zero: assert property (rdAck && wb_adr_i > 8'h20 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	chk_enable_wr: assert property (wrAck |-> comparatorEnable[0] == wb_dat_i[7])
		else $error("enable not written");
	chk_hyst_write: assert property (wrAck |-> hysteresisEnable[0] == (wb_dat_i[7] && wb_dat_i[1]))
		else $error("hysteresis not written");
	chk_hyst_gated: assert property ((hysteresisEnable & ~comparatorEnable) == '0)
		else $error("hysteresis while off");
	// main scenarios
	cover property (wrAck);
	cover property (rdAck && wb_adr_i == 8'h20);
	cover property (rdAck && wb_adr_i > 8'h20);
endmodule
bind cmpc_top cmpc_assertions #(.NUM_INST(NUM_INST)) u_cmpc_assertions (.sys_clk(sys_clk), .rst(rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.comparatorEnable(comparatorEnable), .hysteresisEnable(hysteresisEnable));
`default_nettype wire

/* cmpc_analog_model.sv */
// cmpc_analog_model: comparator cores and timer clock source beside the block.
// assumes the bench says per instance whether the positive input is above the negative one.
`timescale 1ns/1ps
`default_nettype none
module cmpc_analog_model #(parameter int NUM_INST = 8, parameter int TMR_HALF_NS = 100)
(
	// controls
	input wire logic                 sys_clk,
	input wire logic [NUM_INST-1:0]  comparatorEnable,
	input wire logic [NUM_INST-1:0]  posAboveNeg,
	// results
	output wire logic [NUM_INST-1:0] analogResult,
	output wire logic [NUM_INST-1:0] timerClk
);
	logic                tmr = 1'b0;
	logic [NUM_INST-1:0] res = '0;
	// free-running timer source, phase unrelated to sys_clk
	initial #3 forever #(TMR_HALF_NS) tmr = ~tmr;
	assign timerClk = {NUM_INST{tmr}};
	// an unpowered core gives no valid level, so it wanders every cycle
	always @(posedge sys_clk) res <= (comparatorEnable & posAboveNeg) | (~comparatorEnable & ~res);
	assign analogResult = res;
endmodule
`default_nettype wire

/* testbench.sv */
// testbench: register access over wishbone, pin checks on comparator 0, status checks per comparator.
// assumes cmpc_top with eight instances and the analog model beside it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        sysClk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h1;
	logic [3:0]  selNext = 4'h1;
	logic [31:0] datW = 32'h0;
	logic [31:0] datR;
	logic [31:0] rd;
	logic        ack;
	logic [7:0]  above = 8'h00;
	logic [7:0]  ena, hysteresis, pin, res, tclk;
	int          failures = 0;
	int          checks = 0;
	int          cycles = 0;
	cmpc_top u_cmpc_top (.sys_clk(sysClk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack), .analogResult(res),
		.comparatorEnable(ena), .hysteresisEnable(hysteresis), .timerClk(tclk), .comparatorPinOut(pin));
	cmpc_analog_model u_cmpc_analog_model (.sys_clk(sysClk), .comparatorEnable(ena), .posAboveNeg(above),
		.analogResult(res), .timerClk(tclk));
	initial forever #2.5 sysClk = ~sysClk;
	task automatic test_done();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// a hang counts as a failure
	always @(posedge sysClk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge sysClk);
	endtask
	// one classic cycle; the bench never assumes the answer time
	// byte select is set from selNext with the request; only the bench timeout ends a wait
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sysClk);
		{cyc, stb, we, adr, datW, sel} <= {1'b1, 1'b1, w, a, d, selNext};
		@(posedge sysClk);
		while (ack !== 1'b1)
			@(posedge sysClk);
		rd = datR;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic t_reset();
		wb(0, 8'h00, 32'h0);
		chk(rd, 32'h24);
		wb(0, 8'h24, 32'h0);
		chk(rd, 32'h0);
		wb(1, 8'h00, 32'h64); // status bit written high is ignored; reserved bits kept set
		wb(0, 8'h00, 32'h0);
		chk(rd, 32'h24);
	endtask
	// every polarity and filter combination on a live result
	task automatic t_modes();
		logic [7:0] v;
		above <= 8'h01;
		for (int i = 0; i < 4; i++)
		begin
			v = 8'hA4 | (8'(i[0]) << 4) | (8'(i[1]) << 3);
			wb(1, 8'h00, {24'h0, v});
			wait_clk(12);
			wb(0, 8'h00, 32'h0);
			chk(rd, {24'h0, v | (i[0] ? 8'h00 : 8'h40)});
			chk(pin[0], i[0] ? 32'h0 : 32'h1);
		end
	endtask
	task automatic t_off();
		wb(1, 8'h00, 32'h36);
		wait_clk(12);
		wb(0, 8'h00, 32'h0);
		chk(rd, 32'h76);
		chk({ena[0], hysteresis[0]}, 2'b00);
		wb(1, 8'h00, 32'hA6);
		chk(hysteresis[0], 1'b1);
	endtask
	// pin holds between timer falling edges
	task automatic t_sync();
		wb(1, 8'h00, 32'hA5);
		wait_clk(12);
		@(negedge tclk[0]);
		wait_clk(8);
		above <= 8'h80;
		wait_clk(20);
		chk(pin[0], 1'b1);
		@(negedge tclk[0]);
		wait_clk(10);
		chk(pin[0], 1'b0);
	endtask
	task automatic t_inst();
		wb(1, 8'h00, 32'h24);
		wb(1, 8'h1C, 32'hA4);
		selNext = 4'h0;
		wb(1, 8'h1C, 32'h24);
		selNext = 4'h1;
		wait_clk(12);
		wb(0, 8'h20, 32'h0);
		chk(rd, 32'h80);
		chk(ena, 8'h80);
	endtask
	initial
	begin
		wait_clk(2);
		rst <= 1'b0;
		t_reset();
		t_modes();
		t_off();
		t_sync();
		t_inst();
		test_done();
	end
endmodule
`default_nettype wire
